// [dadc_dev.sv]
// Overview of operation
// R1 - result is 13-bit two's complement, sign first
// R2 - sign zero when positive input higher
// R3 - positive full scale code is +4095
// R4 - negative codes two's complement, -4096 minimum
// R5 - frame starts on chip-select falling edge
// R6 - chip select low at power-up: wait
// R7 - sampling begins on first rising clock
// R8 - sampling ends falling edge two, null
// R9 - next 13 clocks send result MSB first
// R10 - data output changes only on falling edges
// R11 - further clocks repeat result LSB first
// R12 - afterwards zeros without limit
// R13 - output high impedance for first two clocks
// R14 - host sends 16 clocks per conversion
// R15 - host takes second byte as low bits
// R16 - falling edge sixteen starts LSB-first copy
// R17 - host samples on rising edges, either polarity
// R18 - one result bit resolved per clock
// R19 - host finishes within 1.2 ms
// R20 - acquisition lasts one and a half clocks
// R21 - chip select high abandons frame, releases output
module dadc_dev
	import dadc_pkg::*;
(
	// power-up and freeze
	input  wire logic                        RESET_N_I,
	input  wire logic                        CE_I,
	// analog levels in lsb units
	input  wire logic [dadc_pkg::AIN_W-1:0]  IN_POS_I,
	input  wire logic [dadc_pkg::AIN_W-1:0]  IN_NEG_I,
	// status, link clock domain
	output logic                             FRAME_O,
	output logic                             CODE_VALID_O,
	output logic [dadc_pkg::RES_W-1:0]       CODE_O,
	// link
	dadc_link_if.dev                         link
);
	import dadc_pkg::*;

	// ********************************
	// code conversion
	// ********************************
	logic signed [AIN_W+1:0]  diff;
	logic                     over_pos;
	logic                     over_neg;
	logic        [RES_W-1:0]  code_conv;

	assign diff      = $signed({2'b00, IN_POS_I}) - $signed({2'b00, IN_NEG_I});
	assign over_pos  = diff > $signed({3'b000, CODE_POS_FS[MAG_W-1:0]});
	assign over_neg  = diff < -$signed({3'b001, CODE_NEG_FS[MAG_W-1:0]});
	// saturate rather than wrap, like a converter at its rails
	assign code_conv = over_pos ? CODE_POS_FS :                // [R3]
	                   over_neg ? CODE_NEG_FS :                // [R4]
	                   diff[RES_W-1:0];                        // [R1] [R2]

	// ********************************
	// arming after power-up
	// ********************************
	logic armed_q;
	logic pwr_hi_q;
	logic armed;

	// a frame needs a real high-to-low edge on chip select
	always_ff @(posedge link.cs_n or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			armed_q <= 1'b0;
		end else begin
			armed_q <= 1'b1;                                   // [R6]
		end
	end

	// chip select already high when power comes up: its next fall is genuine
	always_ff @(posedge RESET_N_I) begin
		pwr_hi_q <= link.cs_n;                                 // [R5]
	end

	// held at zero while the power-up reset is low
	assign armed = RESET_N_I && (armed_q || pwr_hi_q);         // [R6]

	// ********************************
	// acquisition start, rising edges
	// ********************************
	logic acq_q;

	// chip select high clears everything: the link clock may stop
	always_ff @(posedge link.sclk or posedge link.cs_n) begin
		if (link.cs_n) begin
			acq_q <= 1'b0;                                     // [R21]
		end else if (CE_I && armed) begin
			acq_q <= 1'b1;                                     // [R5] [R7]
		end
	end

	// ********************************
	// falling edge counter
	// ********************************
	logic [5:0] fall_q;
	logic [5:0] fall_d;
	logic       fall_go;

	// a leading fall before the first rise (idle-high clock) is not counted
	assign fall_go = CE_I && acq_q;
	assign fall_d  = (fall_q == FALL_SAT) ? fall_q : fall_q + 6'h01;

	always_ff @(negedge link.sclk or posedge link.cs_n) begin
		if (link.cs_n) begin
			fall_q <= FALL_RST;                                // [R21]
		end else if (fall_go) begin
			fall_q <= fall_d;                                  // [R18]
		end
	end

	// ********************************
	// frame phase decode
	// ********************************
	logic in_lead;
	logic at_null;

	// lead: the line stays released for the first two clocks
	assign in_lead = (fall_d < FALL_NULL);                     // [R13]
	assign at_null = (fall_d == FALL_NULL);

	// ********************************
	// result hold
	// ********************************
	logic [RES_W-1:0] code_q;
	logic             valid_q;
	logic             hold_now;

	// sample ends on the second fall: one and a half clocks after the first rise
	assign hold_now = fall_go && at_null;                      // [R20]

	always_ff @(negedge link.sclk or posedge link.cs_n) begin
		if (link.cs_n) begin
			code_q <= CODE_RST;
		end else if (hold_now) begin
			code_q <= code_conv;                               // [R8]
		end
	end

	always_ff @(negedge link.sclk or posedge link.cs_n) begin
		if (link.cs_n) begin
			valid_q <= 1'b0;
		end else if (hold_now) begin
			valid_q <= 1'b1;
		end
	end

	// ********************************
	// serial output selection
	// ********************************
	logic [3:0] msb_idx;
	logic [3:0] lsb_idx;
	logic       in_msb;
	logic       in_lsb;
	logic       bit_msb;
	logic       bit_lsb;
	logic       sdo_d;
	logic [15:0] code_ext;

	// falls 3..15 carry bits 12..0, falls 16..27 carry bits 1..12
	assign in_msb  = (fall_d > FALL_NULL) && (fall_d <= FALL_MSB_LAST);
	assign in_lsb  = (fall_d > FALL_MSB_LAST) && (fall_d <= FALL_LSB_LAST);
	assign msb_idx = 4'(FALL_MSB_LAST - fall_d);
	assign lsb_idx = 4'(fall_d - FALL_MSB_LAST);
	// padded so that every index of the four-bit selectors is in range
	assign code_ext = {3'b000, code_q};
	assign bit_msb = code_ext[msb_idx];                         // [R9]
	assign bit_lsb = code_ext[lsb_idx];                         // [R11] [R16]
	assign sdo_d   = in_msb ? bit_msb :
	                 in_lsb ? bit_lsb :
	                 1'b0;                                      // [R8] [R12]

	// ********************************
	// output drivers, falling edges only
	// ********************************
	logic sdo_q;
	logic oe_q;

	always_ff @(negedge link.sclk or posedge link.cs_n) begin
		if (link.cs_n) begin
			sdo_q <= 1'b0;
		end else if (fall_go) begin
			sdo_q <= sdo_d;                                    // [R10]
		end
	end

	// once driving, only chip select going high lets the line go
	always_ff @(negedge link.sclk or posedge link.cs_n) begin
		if (link.cs_n) begin
			oe_q <= 1'b0;                                      // [R21]
		end else if (fall_go) begin
			oe_q <= oe_q || !in_lead;                          // [R13]
		end
	end

	assign link.sdo    = sdo_q;
	assign link.sdo_oe = oe_q;

	// ********************************
	// status
	// ********************************
	// status follows the frame: chip select high clears it
	assign FRAME_O      = acq_q;
	assign CODE_VALID_O = valid_q;
	assign CODE_O       = code_q;

endmodule : dadc_dev

// [dadc_host.sv]
module dadc_host
	import dadc_pkg::*;
(
	// clock and reset
	input  wire logic                        MCLK_I,
	input  wire logic                        RESET_N_I,
	input  wire logic                        CE_I,
	// request
	input  wire logic                        START_I,
	input  wire logic                        CPOL_I,
	// answer
	output logic                             BUSY_O,
	output logic                             DONE_O,
	output logic [dadc_pkg::RES_W-1:0]       RESULT_O,
	output logic                             NULL_OK_O,
	// link
	dadc_link_if.host                        link
);
	import dadc_pkg::*;

	// ********************************
	// data input synchroniser
	// ********************************
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic filt_q;
	logic filt_d;

	assign filt_d = (s2_q == s3_q) ? s3_q : filt_q;

	always_ff @(posedge MCLK_I) begin
		if (!RESET_N_I) begin
			s1_q   <= 1'b1;
			s2_q   <= 1'b1;
			s3_q   <= 1'b1;
			filt_q <= 1'b1;
		end else if (CE_I) begin
			s1_q   <= link.sdo_w;
			s2_q   <= s1_q;
			s3_q   <= s2_q;
			filt_q <= filt_d;
		end
	end

	// ********************************
	// sequencer
	// ********************************
	dadc_state_t st_q;
	dadc_state_t st_d;
	logic [7:0]  half_q;
	logic [4:0]  bit_q;
	logic        cpol_q;
	logic [15:0] sh_q;
	logic        half_end;
	logic        last_bit;
	logic        rise;

	// half period covers the three-flop input delay
	assign half_end = (half_q == HALF_LAST);
	assign last_bit = (bit_q == BIT_LAST);                     // [R14]
	// low half ending means a rising edge: sample there
	assign rise     = (st_q == DADC_LOW) && half_end;          // [R17]

	always_comb begin
		st_d = st_q;
		case (st_q)
			DADC_IDLE:  if (START_I) st_d = DADC_LEAD;
			DADC_LEAD:  if (half_end) st_d = DADC_LOW;
			DADC_LOW:   if (half_end) st_d = DADC_HIGH;
			DADC_HIGH:  if (half_end) st_d = last_bit ? DADC_TRAIL : DADC_LOW;
			DADC_TRAIL: if (half_end) st_d = DADC_IDLE;
			default:    st_d = DADC_IDLE;
		endcase
	end

	always_ff @(posedge MCLK_I) begin
		if (!RESET_N_I) begin
			st_q   <= DADC_IDLE;
			half_q <= HALF_RST;
			bit_q  <= BIT_RST;
			cpol_q <= 1'b0;
			sh_q   <= SHIFT_RST;
		end else if (CE_I) begin
			st_q   <= st_d;
			half_q <= (st_q == DADC_IDLE || half_end) ? HALF_RST : half_q + 8'h01;
			if (st_q == DADC_IDLE) begin
				bit_q  <= BIT_RST;
				cpol_q <= CPOL_I;
			end else if (st_q == DADC_HIGH && half_end) begin
				bit_q <= bit_q + 5'h01;
			end
			if (rise) begin
				sh_q <= {sh_q[14:0], filt_d};
			end
		end
	end

	// ********************************
	// pins and answer
	// ********************************
	logic sclk_q;
	logic cs_n_q;
	logic done_q;
	logic [RES_W-1:0] res_q;
	logic null_q;

	always_ff @(posedge MCLK_I) begin
		if (!RESET_N_I) begin
			sclk_q <= 1'b0;
			cs_n_q <= 1'b1;                                    // [R6]
			done_q <= 1'b0;
			res_q  <= CODE_RST;
			null_q <= 1'b0;
		end else if (CE_I) begin
			sclk_q <= (st_d == DADC_LOW)  ? 1'b0 :
			          (st_d == DADC_HIGH) ? 1'b1 :
			          (st_q == DADC_IDLE) ? CPOL_I : cpol_q;
			cs_n_q <= (st_d == DADC_IDLE);                     // [R5]
			done_q <= (st_q == DADC_TRAIL) && half_end;
			if ((st_q == DADC_TRAIL) && half_end) begin
				// second byte is the low eight bits
				res_q  <= sh_q[RES_W-1:0];                     // [R15]
				null_q <= !sh_q[RES_W];
			end
		end
	end

	// 16 clocks take far under the hold limit of the sampled charge
	assign link.sclk = sclk_q;                                  // [R19]
	assign link.cs_n = cs_n_q;
	assign BUSY_O    = (st_q != DADC_IDLE);
	assign DONE_O    = done_q;
	assign RESULT_O  = res_q;
	assign NULL_OK_O = null_q;

endmodule : dadc_host

// [dadc_link_if.sv]
interface dadc_link_if;
	logic sclk;
	logic cs_n;
	logic sdo;
	logic sdo_oe;
	logic sdo_w;

	// undriven line modelled as a weak pull-up
	assign sdo_w = sdo_oe ? sdo : 1'b1;

	modport dev (
		input  sclk,
		input  cs_n,
		output sdo,
		output sdo_oe
	);

	modport host (
		output sclk,
		output cs_n,
		input  sdo_w
	);
endinterface : dadc_link_if

// [dadc_link_monitor.sv]
module dadc_link_monitor (
	// link
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdo,
	input wire logic sdo_oe,
	input wire logic sdo_w,
	// device power-up reset
	input wire logic RESET_N_I
);
	timeunit 1ns;
	timeprecision 100ps;

	logic       arm_q, seen_q, p_q;
	logic       hi_q, p2_q, arm;
	logic [5:0] r_q, f_q;

	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n)
			r_q <= 6'h00;
		else
			r_q <= r_q + 6'h01;
	end
	// a fall before the first rise is ignored
	always_ff @(negedge sclk or posedge cs_n) begin
		if (cs_n)
			f_q <= 6'h00;
		else if (r_q != 6'h00)
			f_q <= f_q + 6'h01;
	end
	always_ff @(posedge cs_n or negedge RESET_N_I) begin
		if (!RESET_N_I)
			arm_q <= 1'b0;
		else
			arm_q <= 1'b1;
	end
	// chip select high at power-up: the next fall opens a frame
	always_ff @(posedge RESET_N_I)
		hi_q <= cs_n;
	assign arm = RESET_N_I && (arm_q || hi_q);
	always_ff @(negedge cs_n)
		seen_q <= 1'b1;
	always_ff @(posedge sclk) begin
		p_q  <= sdo;
		p2_q <= p_q;
	end

	AST_HIZ_LEAD: assert property (
		@(posedge sclk) disable iff (cs_n) f_q < 6'h02 |-> !sdo_oe)
		else $error("data driven before null bit");
	AST_NULL_BIT: assert property (
		@(posedge sclk) disable iff (cs_n) arm && f_q == 6'h02 |-> sdo_oe && !sdo)
		else $error("null bit missing");
	AST_UNARMED: assert property (
		@(posedge sclk) disable iff (cs_n) !arm |-> !sdo_oe)
		else $error("unarmed frame drives data");
	AST_CS_RELEASE: assert property (
		@(negedge cs_n) disable iff (!RESET_N_I) !sdo_oe)
		else $error("data still driven at frame start");
	AST_DATA_WIN: assert property (
		@(posedge sclk) disable iff (cs_n) arm && f_q > 6'h02 && f_q < 6'h10 |-> sdo_oe)
		else $error("result bits not driven");
	AST_ACQ_END: assert property (
		@(posedge sclk) disable iff (cs_n) $rose(sdo_oe) |-> f_q == 6'h02)
		else $error("drive began at wrong fall");
	AST_HOST_16: assert property (
		@(posedge cs_n) seen_q |-> r_q == 6'h10)
		else $error("frame without 16 clocks");
	AST_FALL_ONLY: assert property (
		@(negedge sclk) disable iff (cs_n) arm && f_q > 6'h01 |-> sdo == p_q)
		else $error("data moved while clock high");
	AST_LSB_START: assert property (
		@(posedge cs_n) seen_q && arm && f_q == 6'h10 |-> sdo_oe && sdo == p2_q)
		else $error("lsb-first copy not begun at fall 16");

	cover property (@(posedge sclk) arm && f_q == 6'h02 && sdo_oe);
	cover property (@(posedge sclk) !arm && !cs_n);
	cover property (@(posedge cs_n) seen_q && f_q == 6'h10 && sdo_w);
endmodule : dadc_link_monitor

// [dadc_pkg.sv]
package dadc_pkg;

	// ********************************
	// result format
	// ********************************
	localparam int unsigned RES_W      = 13;
	localparam int unsigned MAG_W      = 12;
	localparam int unsigned AIN_W      = 13;
	localparam logic [12:0] CODE_POS_FS = 13'h0fff;
	localparam logic [12:0] CODE_NEG_FS = 13'h1000;
	localparam logic [12:0] CODE_RST    = 13'h0000;

	// ********************************
	// frame timing in falling edges of the link clock
	// ********************************
	localparam logic [5:0] FALL_NULL     = 6'h02;
	localparam logic [5:0] FALL_MSB_LAST = 6'h0f;
	localparam logic [5:0] FALL_LSB_LAST = 6'h1b;
	localparam logic [5:0] FALL_SAT      = 6'h3f;
	localparam logic [5:0] FALL_RST      = 6'h00;

	// ********************************
	// host timing
	// ********************************
	localparam int unsigned MCLK_NS       = 8;
	localparam int unsigned SCLK_HALF_NS  = 64;
	localparam int unsigned HALF_CYC      = (SCLK_HALF_NS + MCLK_NS - 1) / MCLK_NS;
	localparam int unsigned FRAME_CLKS    = 16;
	localparam int unsigned T_CONV_MAX_NS = 1200000;
	localparam logic [4:0]  BIT_LAST      = 5'h0f;
	localparam logic [4:0]  BIT_RST       = 5'h00;
	localparam logic [7:0]  HALF_LAST     = 8'(HALF_CYC - 1);
	localparam logic [7:0]  HALF_RST      = 8'h00;
	localparam logic [15:0] SHIFT_RST     = 16'h0000;

	// ********************************
	// host sequencer states
	// ********************************
	typedef enum logic [2:0] {
		DADC_IDLE  = 3'b000,
		DADC_LEAD  = 3'b001,
		DADC_LOW   = 3'b011,
		DADC_HIGH  = 3'b010,
		DADC_TRAIL = 3'b110
	} dadc_state_t;

endpackage : dadc_pkg

// [tb_diff_adc_serial_readout.sv]
module tb_diff_adc_serial_readout;
	timeunit 1ns;
	timeprecision 100ps;
	import dadc_pkg::*;

	// ****************
	// signals
	// ****************
	logic             mclk = 1'b0;
	logic             h_rst_n = 1'b0;
	logic             d_rst_n = 1'b0;
	logic             start = 1'b0;
	logic             cpol = 1'b0;
	logic [AIN_W-1:0] in_pos = 13'h0000;
	logic [AIN_W-1:0] in_neg = 13'h0000;
	logic [RES_W-1:0] result, code;
	logic             busy, done, null_ok, frame, cvalid;
	logic [15:0]      lf = 16'h0038;
	logic [15:0]      wsh = 16'h0000;
	logic [13:0]      e;
	logic [13:0]      q[$];
	logic [RES_W-1:0] code_seen = 13'h0000;
	logic             valid_seen = 1'b0;
	logic             busy_seen = 1'b0;
	logic             frame_seen = 1'b0;
	int               n_mismatch = 0;
	int               num_checks = 0;
	int               cyc = 0;
	logic [12:0]      tp[7] = '{13'h0000, 13'h0001, 13'h0fff, 13'h1fff, 13'h0000, 13'h0000, 13'h0000};
	logic [12:0]      tn[7] = '{13'h0000, 13'h0000, 13'h0000, 13'h0000, 13'h0001, 13'h1000, 13'h1fff};

	always #4 mclk = ~mclk;

	dadc_link_if link_inst ();
	dadc_dev dadc_dev_inst (.RESET_N_I(d_rst_n), .CE_I(1'b1), .IN_POS_I(in_pos),
		.IN_NEG_I(in_neg), .FRAME_O(frame), .CODE_VALID_O(cvalid), .CODE_O(code),
		.link(link_inst.dev));
	dadc_host dadc_host_inst (.MCLK_I(mclk), .RESET_N_I(h_rst_n), .CE_I(1'b1),
		.START_I(start), .CPOL_I(cpol), .BUSY_O(busy), .DONE_O(done), .RESULT_O(result),
		.NULL_OK_O(null_ok), .link(link_inst.host));
	dadc_link_monitor dadc_link_monitor_inst (.sclk(link_inst.sclk), .cs_n(link_inst.cs_n),
		.sdo(link_inst.sdo), .sdo_oe(link_inst.sdo_oe), .sdo_w(link_inst.sdo_w),
		.RESET_N_I(d_rst_n));

	// ****************
	// helpers
	// ****************
	function automatic logic [15:0] step(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : step

	// the difference saturates, so out-of-range levels clamp to full scale
	function automatic logic [12:0] sat(input logic [12:0] p, input logic [12:0] n);
		int d;
		d = int'(p) - int'(n);
		if (d > 4095)
			d = 4095;
		if (d < -4096)
			d = -4096;
		return 13'(d);
	endfunction : sat

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : tally_and_finish

	// unarmed frames read the pulled-up line: all ones
	task automatic conv(input logic [12:0] p, input logic [12:0] n, input logic arm);
		@(negedge mclk);
		in_pos = p;
		in_neg = n;
		// polarity settles while chip select is still high
		cpol = ~cpol;
		@(negedge mclk);
		start = 1'b1;
		q.push_back(arm ? {1'b1, sat(p, n)} : 14'h1fff);
		@(negedge mclk);
		start = 1'b0;
		// power-up reset with chip select low: the device sits this frame out
		if (!arm) begin
			d_rst_n = 1'b0;
			@(negedge mclk);
			d_rst_n = 1'b1;
		end
		while (done !== 1'b1)
			@(negedge mclk);
	endtask : conv

	// ****************
	// observers
	// ****************
	always @(posedge link_inst.sclk)
		if (!link_inst.cs_n)
			wsh <= {wsh[14:0], link_inst.sdo_w};

	always @(negedge mclk) begin
		if (cvalid === 1'b1) begin
			code_seen = code;
			valid_seen = 1'b1;
		end
		if (frame === 1'b1)
			frame_seen = 1'b1;
		if (busy === 1'b1)
			busy_seen = 1'b1;
		if (done === 1'b1) begin
			e = q.pop_front();
			chk({3'h0, result}, {3'h0, e[12:0]});
			chk({15'h0000, null_ok}, {15'h0000, e[13]});
			chk(wsh, {2'b11, ~e[13], e[12:0]});
			chk({13'h0000, valid_seen, busy_seen, frame_seen}, {13'h0000, e[13], 1'b1, e[13]});
			if (e[13])
				chk({3'h0, code_seen}, {3'h0, e[12:0]});
			valid_seen = 1'b0;
			busy_seen = 1'b0;
			frame_seen = 1'b0;
		end
	end

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 8000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	// ****************
	// sequence
	// ****************
	initial begin
		repeat (16) @(negedge mclk);
		h_rst_n = 1'b1;
		d_rst_n = 1'b1;
		conv(13'h0005, 13'h0000, 1'b0);
		for (int i = 0; i < 7; i++)
			conv(tp[i], tn[i], 1'b1);
		for (int i = 0; i < 5; i++) begin
			lf = step(lf);
			e = {1'b0, lf[12:0]};
			lf = step(lf);
			conv(e[12:0], lf[12:0], 1'b1);
		end
		// third power-up reset while idle: chip select high, so the next fall opens a frame
		d_rst_n = 1'b0;
		@(negedge mclk);
		d_rst_n = 1'b1;
		conv(13'h0100, 13'h0000, 1'b1);
		conv(13'h0000, 13'h0100, 1'b0);
		// let the observer take the last result first
		@(negedge mclk);
		tally_and_finish();
	end
endmodule : tb_diff_adc_serial_readout
